//--- src/flash_front_defines.vh
// Constants for the serial flash interface front end.
// Assumes inclusion by bare name from src/.
`ifndef FLASH_FRONT_DEFINES_VH
`define FLASH_FRONT_DEFINES_VH
// Byte framing
`define BYTE_BITS        4'h8
// Bit position of the protect lock in the status byte
`define PROTECT_LOCK_POS 7
// Opcode of the status write command
`define STATUS_WRITE_OP  8'h01
// Reset value of the status byte: lock clear, both protect levels set
`define STATUS_RESET     8'h0C
// Idle pin levels loaded into the synchroniser at reset, bit order
// {write protect, pause, data in, select, clock}
`define PIN_IDLE_LEVELS  5'h1A
// Sector and block sizes as address bit widths (4 KByte and 32 KByte)
`define SECTOR_ADDR_BITS 12
`define BLOCK_ADDR_BITS  15
// Width of the byte address
`define ADDR_BITS        24
`endif

//--- src/pin_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter             WIDTH     = 5,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // Clocking
   input  wire             clock,
   input  wire             rst_n,
   input  wire             clkEn,
   // Pins in, resynchronised levels out
   input  wire [WIDTH-1:0] pinIn,
   output reg  [WIDTH-1:0] pinOut
);
   reg [WIDTH-1:0] meta_r;

   // ==========================================================
   // Synchroniser; first stage feeds only the second
   // Resets to the idle pin levels so no false edge follows reset
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         pinOut <= RESET_VAL;
      end else if (clkEn) begin
         meta_r <= pinIn;
         pinOut <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- src/flash_spi_front.v
// Serial flash front end: framing, bit shifting, pause and status-write lock.
// Assumes the serial clock, select, data, pause and protect pins come from
// an external host and are asynchronous to clock, which runs much faster.
//
// What this block does
// R1: sample input on rising, output after falling
// R2: selection starts on select falling edge
// R3: host keeps select low whole sequence
// R4: works with clock idling low or high
// R5: host keeps select low while pausing
// R6: pause entry waits for clock low
// R7: pause exit waits for clock low
// R8: output floats while paused, inputs ignored
// R9: deselect during pause resets interface logic
// R10: paused as long as pause pin low
// R11: write-protect low: lock bit blocks status write
// R12: write-protect high: status write always allowed
// R13: decode 4 KByte sectors and 32 KByte blocks
// R14: bytes shifted most significant bit first
// R15: early deselect aborts instruction, back to standby
// R16: pause freezes bit counter and shifters
`timescale 1ns/100ps
`default_nettype none
`include "flash_front_defines.vh"
module flash_spi_front #(
   parameter ADDR_W = 24
) (
   // Clocking
   input  wire              clock,
   input  wire              rst_n,
   input  wire              clkEn,
   // Serial pins from the host
   input  wire              serialClk,
   input  wire              selectN,
   input  wire              serialIn,
   input  wire              pauseN,
   input  wire              writeProtectN,
   // Serial output pin, two signals
   output wire              serialOut,
   output wire              serialOutEn,
   // Core side: received bytes
   output reg  [7:0]        rxByte,
   output reg               rxValid,
   output reg  [3:0]        rxIndex,
   output reg  [7:0]        opcode,
   // Core side: byte to send, loaded at each byte boundary
   input  wire [7:0]        txByte,
   output wire              txTake,
   // Core side: address decode and status
   output reg  [ADDR_W-1:0] address,
   output wire [ADDR_W-13:0] sectorIndex,
   output wire [ADDR_W-16:0] blockIndex,
   output reg  [7:0]        status,
   output reg               statusWriteDone,
   output reg               statusWriteRejected,
   output reg               aborted,
   output wire              selected,
   output wire              paused
);
   // Interface states
   localparam ST_IDLE  = 2'h0;
   localparam ST_SHIFT = 2'h1;
   localparam ST_PAUSE = 2'h2;

   // Synchronised pin levels, order fixed at the synchroniser input
   wire [4:0] pinS;
   wire       sckS = pinS[0];
   wire       selS = pinS[1];
   wire       siS  = pinS[2];
   wire       holdS = pinS[3];
   wire       wpS  = pinS[4];

   // Framing state, edge history and shifters
   reg  [1:0] state_r;
   reg        sckD_r;
   reg        selD_r;
   reg  [2:0] bitCnt_r;
   reg  [7:0] shiftIn_r;
   reg  [7:0] shiftOut_r;
   reg        outBit_r;
   reg        txTake_r;

   // Edge detectors; each serial clock phase must last longer than one clock,
   // otherwise an edge is lost in the synchroniser
   wire sckRise = sckS & ~sckD_r;
   wire sckFall = ~sckS & sckD_r;
   wire selFall = ~selS & selD_r;
   wire [7:0] nextByte = {shiftIn_r[6:0], siS};

   // Lock check, shared by the write path
   function statusWriteAllowed;
      input wp;
      input [7:0] st;
      begin
         statusWriteAllowed = wp | ~st[`PROTECT_LOCK_POS]; // R11 R12
      end
   endfunction

   // ==========================================================
   // Pin synchroniser
   pin_sync #(
      .WIDTH     (5),
      .RESET_VAL (`PIN_IDLE_LEVELS)
   ) uSync (
      .clock    (clock),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .pinIn    ({writeProtectN, pauseN, serialIn, selectN, serialClk}),
      .pinOut   (pinS)
   );

   assign selected    = (state_r != ST_IDLE);
   assign paused      = (state_r == ST_PAUSE);
   assign serialOut   = outBit_r;
   assign serialOutEn = (state_r == ST_SHIFT) & ~selS; // R8
   assign txTake      = txTake_r;
   assign sectorIndex = address[ADDR_W-1:`SECTOR_ADDR_BITS]; // R13
   assign blockIndex  = address[ADDR_W-1:`BLOCK_ADDR_BITS];  // R13

   // ==========================================================
   // Framing, shifting and pause control
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r             <= ST_IDLE;
         sckD_r              <= 1'b0;
         selD_r              <= 1'b1;
         bitCnt_r            <= 3'h0;
         shiftIn_r           <= 8'h00;
         shiftOut_r          <= 8'h00;
         outBit_r            <= 1'b0;
         txTake_r            <= 1'b0;
         rxByte              <= 8'h00;
         rxValid             <= 1'b0;
         rxIndex             <= 4'h0;
         opcode              <= 8'h00;
         address             <= {ADDR_W{1'b0}};
         status              <= `STATUS_RESET;
         statusWriteDone     <= 1'b0;
         statusWriteRejected <= 1'b0;
         aborted             <= 1'b0;
      end else if (clkEn) begin
         sckD_r              <= sckS;
         selD_r              <= selS;
         rxValid             <= 1'b0;
         txTake_r            <= 1'b0;
         statusWriteDone     <= 1'b0;
         statusWriteRejected <= 1'b0;
         aborted             <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               // Only a falling select opens a sequence, a held-low select does not
               if (selFall) begin // R2
                  state_r    <= ST_SHIFT;
                  bitCnt_r   <= 3'h0;
                  rxIndex    <= 4'h0;
                  shiftOut_r <= txByte;
                  outBit_r   <= txByte[7];
                  txTake_r   <= 1'b1;
               end
            end
            ST_SHIFT: begin
               if (selS) begin
                  // Mid-byte deselect abandons the instruction
                  state_r <= ST_IDLE; // R15
                  aborted <= (bitCnt_r != 3'h0); // R15
               end else if (!holdS && !sckS) begin
                  // Taken only with the clock low, so no half bit is lost
                  state_r <= ST_PAUSE; // R6 R16
               end else if (sckRise) begin
                  // Edges only, so clock idle level does not matter
                  shiftIn_r <= nextByte; // R1 R4 R14
                  bitCnt_r  <= bitCnt_r + 3'h1;
                  if (bitCnt_r == 3'h7) begin
                     rxByte  <= nextByte;
                     rxValid <= 1'b1;
                     if (rxIndex != 4'hF)
                        rxIndex <= rxIndex + 4'h1;
                     if (rxIndex == 4'h0)
                        opcode <= nextByte;
                     if (rxIndex >= 4'h1 && rxIndex <= 4'h3)
                        address <= {address[ADDR_W-9:0], nextByte};
                     if (rxIndex == 4'h1 && opcode == `STATUS_WRITE_OP) begin
                        if (statusWriteAllowed(wpS, status)) begin // R11 R12
                           status          <= {nextByte[7], 2'b00, 1'b0, nextByte[3:2], status[1:0]};
                           statusWriteDone <= 1'b1;
                        end else begin
                           statusWriteRejected <= 1'b1; // R11
                        end
                     end
                  end
               end else if (sckFall) begin
                  // Output changes after the falling edge
                  if (bitCnt_r == 3'h0) begin
                     shiftOut_r <= txByte; // R1 R14
                     outBit_r   <= txByte[7];
                     txTake_r   <= 1'b1;
                  end else begin
                     outBit_r   <= shiftOut_r[3'h7 - bitCnt_r]; // R1 R14
                  end
               end
            end
            ST_PAUSE: begin
               // Counters and shifters hold here; clock and data ignored
               if (selS) begin
                  state_r  <= ST_IDLE; // R9
                  bitCnt_r <= 3'h0;    // R9
                  rxIndex  <= 4'h0;
                  aborted  <= 1'b1;
               end else if (holdS && !sckS) begin
                  // A deselect above wins over a resume in the same cycle
                  state_r <= ST_SHIFT; // R7 R10
                  sckD_r  <= 1'b0;     // R16
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- verif/flash_front_checker.sv
// Assertions on the flash serial front end ports.
// Assumes clkEn is held high by whoever drives the block.
`timescale 1ns/100ps
`default_nettype none
module flash_front_checker #(
   parameter ADDR_W = 24
) (
   // Watched ports
   input wire logic                clock,
   input wire logic                rst_n,
   input wire logic                selectN,
   input wire logic                pauseN,
   input wire logic                writeProtectN,
   input wire logic                serialOutEn,
   input wire logic                rxValid,
   input wire logic [7:0]          opcode,
   input wire logic                txTake,
   input wire logic [ADDR_W-1:0]   address,
   input wire logic [ADDR_W-13:0]  sectorIndex,
   input wire logic [ADDR_W-16:0]  blockIndex,
   input wire logic [7:0]          status,
   input wire logic                statusWriteDone,
   input wire logic                statusWriteRejected,
   input wire logic                aborted,
   input wire logic                selected,
   input wire logic                paused
);
   // ==========
   // One domain, so clock and reset are stated once
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_float_paused: assert property (paused |-> !serialOutEn) else $error("driven while paused");
   a_idle_float: assert property (!selected |-> !serialOutEn) else $error("driven while idle");
   a_select_take: assert property ($rose(selected) |-> txTake) else $error("no load at select");
   a_reject_lock: assert property (statusWriteRejected |-> status[7] && !writeProtectN && $stable(status))
      else $error("bad reject");
   a_write_cause: assert property (statusWriteDone |-> rxValid && opcode == 8'h01) else $error("stray write");
   a_sector_map: assert property (sectorIndex == address[ADDR_W-1:12] && blockIndex == address[ADDR_W-1:15])
      else $error("bad sector or block");
   a_abort_idle: assert property (aborted |-> ##[0:1] (!selected && !paused)) else $error("abort left busy");
   // Sync lag is covered by asking for four low samples first
   a_pause_stays: assert property ((paused && !pauseN && !selectN) [*4] |=> paused) else $error("left pause");
   a_rx_pulse: assert property (rxValid |=> !rxValid) else $error("byte pulse too long");
endmodule
bind flash_spi_front flash_front_checker #(.ADDR_W(ADDR_W)) i_chk (.clock, .rst_n, .selectN, .pauseN, .writeProtectN,
   .serialOutEn, .rxValid, .opcode, .txTake, .address, .sectorIndex, .blockIndex, .status,
   .statusWriteDone, .statusWriteRejected, .aborted, .selected, .paused);
`default_nettype wire

//--- verif/spi_host_model.sv
// Behavioural host controller for the serial pins, 200 ns link period.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   // Serial pins
   output var logic serialClk,
   output var logic selectN,
   output var logic serialIn,
   output var logic pauseN,
   input  wire logic serialOut
);
   logic       idleHigh = 1'b0;
   logic [7:0] got = 8'h00;
   // ==========
   // Pins idle, clock parked, device deselected
   initial begin
      serialClk = 1'b0;
      selectN   = 1'b1;
      serialIn  = 1'b0;
      pauseN    = 1'b1;
   end
   task automatic open_frame();
      serialClk = idleHigh;
      #100 selectN = 1'b0;
      #100;
   endtask
   // Read back late in the high phase, well clear of the output update
   task automatic shift(input logic [7:0] d, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         serialClk = 1'b0;
         serialIn = d[i];
         #100 serialClk = 1'b1;
         #100 got = {got[6:0], serialOut};
      end
      serialClk = idleHigh;
      serialIn = ~serialIn; // Released line flips so stale data never matches
   endtask
   task automatic close_frame();
      #100 selectN = 1'b1;
      #200;
   endtask
   task automatic pause_pin(input logic v);
      pauseN = v;
   endtask
endmodule
`default_nettype wire

//--- verif/flash_spi_front_bench.sv
// Self-checking bench for the flash serial front end.
// Assumes the host model drives the serial pins; clkEn held high.
`timescale 1ns/100ps
`default_nettype none
module flash_spi_front_bench;
   logic clock, rst_n, writeProtectN, serialClk, selectN, serialIn, pauseN, serialOut, serialOutEn;
   logic [7:0] rxByte, opcode, status;
   logic [23:0] address;
   logic [11:0] sectorIndex;
   logic [8:0] blockIndex;
   logic [3:0] rxIndex;
   logic selected, paused, aborted, wDone, wRej;
   int mismatches = 0, check_count = 0, nAbort = 0, nDone = 0, nRej = 0;
   flash_spi_front i_dut (.clock, .rst_n, .clkEn(1'b1), .serialClk, .selectN, .serialIn, .pauseN, .writeProtectN,
      .serialOut, .serialOutEn, .rxByte, .rxValid(), .rxIndex, .opcode, .txByte(8'hA5), .txTake(), .address,
      .sectorIndex, .blockIndex, .status, .statusWriteDone(wDone), .statusWriteRejected(wRej), .aborted,
      .selected, .paused);
   spi_host_model i_host (.serialClk, .selectN, .serialIn, .pauseN, .serialOut);
   // ==========
   // Clock and pulse tallies
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      nAbort += aborted;
      nDone += wDone;
      nRej += wRej;
   end
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_modes();
      for (int m = 0; m < 2; m++) begin
         i_host.idleHigh = m[0];
         i_host.open_frame();
         // A different opcode per mode, so a stale one cannot pass
         i_host.shift(m ? 8'h6A : 8'h9C, 8);
         chk("serial out", 24'hA5, 24'(i_host.got));
         #200 chk("opcode", m ? 24'h6A : 24'h9C, 24'(opcode));
         i_host.close_frame();
      end
   endtask
   task automatic t_addr();
      i_host.idleHigh = 1'b0;
      i_host.open_frame();
      i_host.shift(8'h03, 8);
      chk("serial out", 24'hA5, 24'(i_host.got));
      i_host.shift(8'h12, 8);
      i_host.shift(8'h34, 8);
      i_host.shift(8'h56, 8);
      #200 chk("address", 24'h123456, address);
      chk("sector", 24'h123, 24'(sectorIndex));
      chk("block", 24'h024, 24'(blockIndex));
      chk("byte index", 24'h4, 24'(rxIndex));
      i_host.close_frame();
   endtask
   task automatic t_abort(input logic inPause);
      int a;
      a = nAbort;
      i_host.open_frame();
      i_host.shift(8'hF0, 3);
      i_host.pause_pin(!inPause);
      #300 i_host.close_frame();
      i_host.pause_pin(1'b1);
      chk("abort count", 24'(a + 1), 24'(nAbort));
      chk("selected", 24'h0, 24'(selected));
   endtask
   // Clock pulses during the pause must not count as bits
   task automatic t_pause();
      i_host.open_frame();
      i_host.shift(8'h3C, 4);
      i_host.pause_pin(1'b0);
      #300 chk("paused", 24'h1, 24'(paused));
      chk("output enable", 24'h0, 24'(serialOutEn));
      i_host.shift(8'hFF, 2);
      i_host.pause_pin(1'b1);
      #300 i_host.shift(8'hC0, 4);
      #200 chk("resumed byte", 24'h3C, 24'(rxByte));
      i_host.close_frame();
   endtask
   task automatic t_status();
      logic [7:0] dat [4] = '{8'h8C, 8'h00, 8'h00, 8'h04};
      logic [7:0] expS [4] = '{8'h8C, 8'h8C, 8'h00, 8'h04};
      logic [3:0] wp = 4'b0101;
      int d, r;
      for (int i = 0; i < 4; i++) begin
         d = nDone;
         r = nRej;
         @(negedge clock) writeProtectN = wp[i];
         i_host.open_frame();
         i_host.shift(8'h01, 8);
         i_host.shift(dat[i], 8);
         #200 chk("status", 24'(expS[i]), 24'(status));
         chk("writes", 24'(d + (i != 1)), 24'(nDone));
         chk("rejects", 24'(r + (i == 1)), 24'(nRej));
         i_host.close_frame();
      end
   endtask
   initial begin
      rst_n = 1'b0;
      writeProtectN = 1'b1;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      t_modes();
      t_addr();
      t_abort(1'b0);
      t_pause();
      t_abort(1'b1);
      t_status();
      end_sim();
   end
   // Hang guard, far beyond the roughly 34 us the run needs
   initial begin
      #1000000 mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
